// ### pkg/hps_pkg.sv
// Purpose: Shared constants and types of the hall switch parameter block
// Assumes: sys_clk at 50 MHz
// Notes: Signal unit is one zero-field offset step
package hps_pkg;
    localparam int RAW_W = 14;
    localparam int GAIN_W = 14;
    localparam int GAIN_FRAC = 11;
    localparam int OFF_W = 12;
    localparam logic [OFF_W-1:0] OFF_BIAS = 12'h800;
    localparam int REL_W = 8;
    localparam int OPR_W = 9;
    localparam int LVL_SHIFT = 1;
    localparam logic [RAW_W-1:0] SIG_FULL = 14'h03ff;
    localparam int UIB_W = 13;
    localparam int UIB_N = 4;
    localparam int TC_W = 10;
    localparam logic [TC_W-1:0] TC_RESET = 10'h100;
    localparam int GRP_LO = 8;
    localparam int LIN_LO = 3;
    localparam int LIN_W = 5;
    localparam int QUAD_W = 3;
    localparam int GUARD_W = 2;
    localparam int FMT_W = 3;
    localparam logic [FMT_W-1:0] FMT_DIGITAL = 3'h0;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 14;
    localparam logic [ADDR_W-1:0] A_TC = 4'h0;
    localparam logic [ADDR_W-1:0] A_GAIN = 4'h1;
    localparam logic [ADDR_W-1:0] A_OFF = 4'h2;
    localparam logic [ADDR_W-1:0] A_REL = 4'h3;
    localparam logic [ADDR_W-1:0] A_OPR = 4'h4;
    localparam logic [ADDR_W-1:0] A_UIB0 = 4'h5;
    localparam logic [ADDR_W-1:0] A_GUARD = 4'h9;
    localparam logic [ADDR_W-1:0] A_RAW = 4'ha;
    localparam logic [ADDR_W-1:0] A_PROC = 4'hb;
    localparam int CLK_NS = 20;
    localparam int BIT_TIME_NS = 20000;
    localparam int BIT_CYC = BIT_TIME_NS / CLK_NS;
    localparam int CNT_W = 12;
    localparam int FRAME_BITS = 2 + ADDR_W + DATA_W;
    localparam logic [4:0] REPLY_BITS = 5'h0e;
    localparam logic [4:0] ACK_BITS = 5'h01;
    localparam logic [1:0] BOOT_CYC = 2'h3;
    typedef enum logic [1:0] {OP_READ = 2'b00, OP_WRITE = 2'b01, OP_STORE = 2'b10, OP_NONE = 2'b11} hps_op_t;
    typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_FRAME = 1'b1} hps_rx_st_t;
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} hps_tx_st_t;
endpackage : hps_pkg

// ### design/hps_supply_rx.sv
// Purpose: Turns supply-level frames into commands
// Assumes: supply_hi is an asynchronous comparator level
// Notes: Rising edge starts a frame; op, address, data follow MSB first
`timescale 1ns/1ns
module hps_supply_rx #(
    parameter int BIT_CYC = hps_pkg::BIT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic supply_hi,
    output logic cmd_valid,
    output hps_pkg::hps_op_t cmd_op,
    output logic [hps_pkg::ADDR_W-1:0] cmd_addr,
    output logic [hps_pkg::DATA_W-1:0] cmd_data
);
    import hps_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        hps_rx_st_t st;
        logic [CNT_W-1:0] cnt;
        logic [4:0] nbit;
        logic [FRAME_BITS-1:0] sh;
        logic vld;
    } hps_rx_t;
    hps_rx_t r;
    hps_rx_t next_r;
    always_comb begin
        next_r = r;
        next_r.s1 = supply_hi;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.vld = 1'b0;
        case (r.st)
            RX_IDLE: begin
                if (r.s2 && !r.s3) begin
                    next_r.st = RX_FRAME;
                    next_r.cnt = CNT_W'(BIT_CYC + BIT_CYC / 2 - 1);
                    next_r.nbit = '0;
                end
            end
            RX_FRAME: begin
                if (r.cnt == '0) begin
                    next_r.sh = {r.sh[FRAME_BITS-2:0], r.s2};
                    next_r.cnt = CNT_W'(BIT_CYC - 1);
                    next_r.nbit = r.nbit + 5'h01;
                    if (r.nbit == 5'(FRAME_BITS - 1)) begin
                        next_r.vld = 1'b1;
                        next_r.st = RX_IDLE;
                    end
                end else begin
                    next_r.cnt = r.cnt - CNT_W'(1);
                end
            end
            default: next_r.st = RX_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign cmd_valid = r.vld;
    assign cmd_op = hps_op_t'(r.sh[FRAME_BITS-1 -: 2]);
    assign cmd_addr = r.sh[DATA_W +: ADDR_W];
    assign cmd_data = r.sh[DATA_W-1:0];
endmodule : hps_supply_rx

// ### design/hps_signal_path.sv
// Purpose: Gain, offset, saturation and hysteresis comparator
// Assumes: raw_sample is signed and on sys_clk
// Notes: Threshold step is two signal steps
`timescale 1ns/1ns
module hps_signal_path (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [hps_pkg::RAW_W-1:0] raw_sample,
    input wire logic raw_valid,
    input wire logic [hps_pkg::GAIN_W-1:0] gain,
    input wire logic [hps_pkg::OFF_W-1:0] zero_field_offset,
    input wire logic [hps_pkg::REL_W-1:0] release_lvl,
    input wire logic [hps_pkg::OPR_W-1:0] operate_lvl,
    output logic [hps_pkg::RAW_W-1:0] proc_value,
    output logic switched_on
);
    import hps_pkg::*;
    localparam int W = RAW_W + GAIN_W;
    typedef struct packed {
        logic [RAW_W-1:0] proc;
        logic on;
    } hps_dsp_t;
    hps_dsp_t d;
    hps_dsp_t next_d;
    logic signed [W-1:0] prod;
    logic signed [W-1:0] offs;
    logic signed [W-1:0] sum;
    logic signed [W-1:0] top;
    function automatic logic [RAW_W:0] lvl(input logic [OPR_W-1:0] v);
        return (RAW_W + 1)'(v) << LVL_SHIFT;
    endfunction : lvl
    always_comb begin
        next_d = d;
        offs = W'($signed({1'b0, zero_field_offset}) - $signed({1'b0, OFF_BIAS}));
        prod = $signed(raw_sample) * $signed(gain);
        sum = (prod >>> GAIN_FRAC) + offs;
        top = (offs < 0) ? offs + W'(SIG_FULL) : W'(SIG_FULL);
        if (raw_valid) begin
            next_d.proc = (sum < 0 || top < 0) ? '0 : (sum > top ? RAW_W'(top) : RAW_W'(sum));
        end
        if ({1'b0, d.proc} > lvl(operate_lvl)) begin
            next_d.on = 1'b1;
        end else if ({1'b0, d.proc} < lvl(OPR_W'(release_lvl))) begin
            next_d.on = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            d <= '0;
        end else begin
            d <= next_d;
        end
    end
    assign proc_value = d.proc;
    assign switched_on = d.on;
    a_switch_operate: assert property (@(posedge sys_clk) disable iff (!rst_b)
        {1'b0, d.proc} > lvl(operate_lvl) |=> switched_on) else $error("Switch missed operate");
    a_sat_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
        raw_valid && top >= 0 |=> W'(proc_value) <= $past(top)) else $error("Signal above limit");
endmodule : hps_signal_path

// ### design/hps_param_regs.sv
// Purpose: Parameter registers, lock and readback of the hall switch
// Assumes: Commands arrive by supply modulation; rst_b is power-on
// Notes: The lock cell is non-volatile and lives outside this logic
`timescale 1ns/1ns
// Function
// - Temperature register holds group selector, 5-bit linear, 3-bit quadratic coefficient.
// - Group 0,2,1,3 map to steepest negative up to positive ranges; 1 default.
// - Gain coefficient drives the multiplier, signed span four, fine steps.
// - Zero-field offset drives the adder, spanning minus to plus supply.
// - Negative offset caps the signal at offset plus full scale.
// - Release threshold spans half scale, operate threshold full scale.
// - Four addressed 13-bit user blocks, read and write while unlocked.
// - Lock bit zero freezes registers; locked device ignores every command.
// - Lock acts only after the next power cycle following its write.
// - Nothing can clear the lock bit once set.
// - Raw sample register returns filtered field before processing.
// - Processed value is returned with bit order reversed.
// - Processed value reads zero unless output format is zero.
// - Processed signal is gain times field plus offset.
// - Output goes low above operate, high below release, else holds.
// - Commands come by supply modulation; replies go out on the output pin.
module hps_param_regs #(
    parameter int BIT_CYC = hps_pkg::BIT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic supply_hi,
    input wire logic lock_cell,
    input wire logic [hps_pkg::RAW_W-1:0] raw_sample,
    input wire logic raw_valid,
    input wire logic [hps_pkg::FMT_W-1:0] output_format,
    output logic out_pin,
    output logic lock_cell_set,
    output logic [3:0] comp_range,
    output logic [hps_pkg::LIN_W-1:0] linear_temp_coeff,
    output logic [hps_pkg::QUAD_W-1:0] quadratic_temp_coeff
);
    import hps_pkg::*;

    typedef struct packed {
        logic l1;
        logic l2;
        logic [1:0] boot;
        logic booted;
        logic locked;
        logic [TC_W-1:0] tc;
        logic [GAIN_W-1:0] gain;
        logic [OFF_W-1:0] off;
        logic [REL_W-1:0] rel;
        logic [OPR_W-1:0] opr;
        logic [UIB_N-1:0][UIB_W-1:0] uib;
        logic [GUARD_W-1:0] guard;
        hps_tx_st_t tx;
        logic [DATA_W-1:0] rsh;
        logic [CNT_W-1:0] rcnt;
        logic [4:0] rnum;
        logic out;
    } hps_main_t;

    hps_main_t m;
    hps_main_t next_m;
    logic cmd_valid;
    hps_op_t cmd_op;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data;
    logic [RAW_W-1:0] proc_value;
    logic sw_on;
    logic acc;
    logic wr_hit;
    logic rd_hit;
    logic [DATA_W-1:0] rd_word;
    logic [ADDR_W-1:0] uib_idx;

    function automatic logic [DATA_W-1:0] bit_rev(input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] o;
        o = '0;
        for (int i = 0; i < DATA_W; i++) begin
            o[i] = v[DATA_W-1-i];
        end
        return o;
    endfunction : bit_rev

    // One-hot range, bit 0 steepest negative, bit 3 positive
    function automatic logic [3:0] range_decode(input logic [1:0] grp);
        logic [3:0] o;
        o = 4'h4;
        case (grp)
            2'b00: o = 4'h1;
            2'b10: o = 4'h2;
            2'b01: o = 4'h4;
            2'b11: o = 4'h8;
            default: o = 4'h4;
        endcase
        return o;
    endfunction : range_decode

    hps_supply_rx #(
        .BIT_CYC(BIT_CYC)
    ) u_rx (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .supply_hi(supply_hi),
        .cmd_valid(cmd_valid),
        .cmd_op(cmd_op),
        .cmd_addr(cmd_addr),
        .cmd_data(cmd_data)
    );

    hps_signal_path u_dsp (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .raw_sample(raw_sample),
        .raw_valid(raw_valid),
        .gain(m.gain),
        .zero_field_offset(m.off),
        .release_lvl(m.rel),
        .operate_lvl(m.opr),
        .proc_value(proc_value),
        .switched_on(sw_on)
    );

    // Commands count only after the lock cell has been sampled
    assign acc = cmd_valid && m.booted && !m.locked;
    assign wr_hit = acc && (cmd_op == OP_WRITE);
    assign rd_hit = acc && (cmd_op == OP_READ);
    assign uib_idx = cmd_addr - A_UIB0;

    always_comb begin
        rd_word = '0;
        case (cmd_addr)
            A_TC: rd_word = DATA_W'(m.tc);
            A_GAIN: rd_word = DATA_W'(m.gain);
            A_OFF: rd_word = DATA_W'(m.off);
            A_REL: rd_word = DATA_W'(m.rel);
            A_OPR: rd_word = DATA_W'(m.opr);
            A_GUARD: rd_word = DATA_W'(m.guard);
            A_RAW: rd_word = raw_sample;
            A_PROC: begin
                if (output_format == FMT_DIGITAL) begin
                    rd_word = bit_rev(proc_value);
                end else begin
                    rd_word = '0;
                end
            end
            default: begin
                if (cmd_addr >= A_UIB0 && cmd_addr < A_GUARD) begin
                    rd_word = DATA_W'(m.uib[uib_idx[1:0]]);
                end
            end
        endcase
    end

    always_comb begin
        next_m = m;
        next_m.l1 = lock_cell;
        next_m.l2 = m.l1;
        // Lock cell is sampled once per power-up
        if (!m.booted) begin
            if (m.boot == BOOT_CYC) begin
                next_m.booted = 1'b1;
                next_m.locked = m.l2;
            end else begin
                next_m.boot = m.boot + 2'h1;
            end
        end
        // Reply shifter on the output pin
        if (m.tx == TX_SEND) begin
            if (m.rcnt == '0) begin
                next_m.rcnt = CNT_W'(BIT_CYC - 1);
                next_m.rsh = {m.rsh[DATA_W-2:0], 1'b0};
                next_m.rnum = m.rnum - 5'h01;
                if (m.rnum == ACK_BITS) begin
                    next_m.tx = TX_IDLE;
                end
            end else begin
                next_m.rcnt = m.rcnt - CNT_W'(1);
            end
        end
        if (acc) begin
            case (cmd_op)
                OP_READ: begin
                    next_m.tx = TX_SEND;
                    next_m.rsh = rd_word;
                    next_m.rnum = REPLY_BITS;
                    next_m.rcnt = CNT_W'(BIT_CYC - 1);
                end
                OP_WRITE, OP_STORE: begin
                    next_m.tx = TX_SEND;
                    next_m.rsh = {1'b1, {(DATA_W - 1){1'b0}}};
                    next_m.rnum = ACK_BITS;
                    next_m.rcnt = CNT_W'(BIT_CYC - 1);
                end
                default: next_m.tx = m.tx;
            endcase
        end
        if (wr_hit) begin
            case (cmd_addr)
                A_TC: next_m.tc = cmd_data[TC_W-1:0];
                A_GAIN: next_m.gain = cmd_data[GAIN_W-1:0];
                A_OFF: next_m.off = cmd_data[OFF_W-1:0];
                A_REL: next_m.rel = cmd_data[REL_W-1:0];
                A_OPR: next_m.opr = cmd_data[OPR_W-1:0];
                A_GUARD: begin
                    next_m.guard = cmd_data[GUARD_W-1:0] | {1'b0, m.guard[0]};
                end
                default: begin
                    if (cmd_addr >= A_UIB0 && cmd_addr < A_GUARD) begin
                        next_m.uib[uib_idx[1:0]] = cmd_data[UIB_W-1:0];
                    end
                end
            endcase
        end
        // Pin is low while switched on, unless a reply is going out
        if (m.tx == TX_SEND) begin
            next_m.out = m.rsh[DATA_W-1];
        end else begin
            next_m.out = !sw_on;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            m <= '{tc: TC_RESET, out: 1'b1, tx: TX_IDLE, default: '0};
        end else begin
            m <= next_m;
        end
    end

    assign out_pin = m.out;
    assign lock_cell_set = m.guard[0];
    assign comp_range = range_decode(m.tc[GRP_LO +: 2]);
    assign linear_temp_coeff = m.tc[LIN_LO +: LIN_W];
    assign quadratic_temp_coeff = m.tc[QUAD_W-1:0];

    a_guard_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.guard[0] |=> m.guard[0]) else $error("Lock bit cleared");

    a_lock_persists: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.locked |=> m.locked) else $error("Lock dropped without power cycle");

    a_lock_delayed: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.booted && !m.locked |=> !m.locked) else $error("Lock took effect without power cycle");

    a_locked_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.locked && cmd_valid |=> $stable(m.tc) && $stable(m.gain) && $stable(m.uib) && $stable(m.guard))
        else $error("Locked register changed");

    a_locked_silent: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.locked |-> m.tx == TX_IDLE) else $error("Locked device replied");

    a_read_reply: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_hit |=> m.tx == TX_SEND && m.rnum == REPLY_BITS && m.rsh == $past(rd_word))
        else $error("Read reply not started");

    a_reply_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.tx == TX_SEND |=> out_pin == $past(m.rsh[DATA_W-1])) else $error("Reply bit not on pin");

    a_proc_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_hit && cmd_addr == A_PROC && output_format != FMT_DIGITAL |=> m.rsh == '0)
        else $error("Processed value leaked");

    a_proc_reversed: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_hit && cmd_addr == A_PROC && output_format == FMT_DIGITAL |=> m.rsh == bit_rev($past(proc_value)))
        else $error("Processed value not reversed");

    a_raw_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_hit && cmd_addr == A_RAW |=> m.rsh == $past(raw_sample)) else $error("Raw sample not returned");

    a_tc_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr == A_TC |=> m.tc == $past(cmd_data[TC_W-1:0])) else $error("Temp coeff not written");

    a_uib_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr == A_UIB0 |=> m.uib[0] == $past(cmd_data[UIB_W-1:0])) else $error("User block lost");

    a_range_onehot: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $onehot(comp_range)) else $error("Range decode not one-hot");

    a_switch_pin: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.tx == TX_IDLE && sw_on |=> !out_pin) else $error("Pin not low when switched on");

    a_pin_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.tx == TX_IDLE && !sw_on
        |=> out_pin)
        else $error("Pin not high when switched off");

    a_gain_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr == A_GAIN
        |=> m.gain == $past(cmd_data[GAIN_W-1:0]))
        else $error("Gain not written");

    a_off_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr == A_OFF
        |=> m.off == $past(cmd_data[OFF_W-1:0]))
        else $error("Offset not written");

    a_rel_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr == A_REL
        |=> m.rel == $past(cmd_data[REL_W-1:0]))
        else $error("Release level not written");

    a_opr_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr == A_OPR
        |=> m.opr == $past(cmd_data[OPR_W-1:0]))
        else $error("Operate level not written");

    a_guard_merge: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr == A_GUARD
        |=> m.guard[0] == ($past(m.guard[0]) || $past(cmd_data[0])))
        else $error("Lock bit write not merged");

    a_group_two: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.tc[GRP_LO +: 2] == 2'b10
        |-> comp_range == 4'h2)
        else $error("Group two decoded wrongly");

    a_uib_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_hit && cmd_addr == A_UIB0
        |=> m.rsh == DATA_W'($past(m.uib[0])))
        else $error("User block not returned");

    a_spare_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_hit && cmd_addr > A_PROC
        |=> $stable(m.tc) && $stable(m.uib) && $stable(m.guard))
        else $error("Spare address changed a register");

    a_ack_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
        acc && (cmd_op == OP_WRITE || cmd_op == OP_STORE)
        |=> m.tx == TX_SEND && m.rnum == ACK_BITS && m.rsh[DATA_W-1])
        else $error("Acknowledge not started");

    a_reply_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        m.tx == TX_SEND && m.rcnt == '0 && m.rnum == ACK_BITS
        |=> m.tx == TX_IDLE)
        else $error("Reply did not end");

    a_boot_sample: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !m.booted && m.boot == BOOT_CYC
        |=> m.booted && m.locked == $past(m.l2))
        else $error("Lock cell not sampled at power-up");
endmodule : hps_param_regs

// ### sim/hps_programmer.sv
// Purpose: Programmer model that frames commands on the supply and reads the output pin
// Assumes: Frame and reply timing of the parameter block at a short bit time
// Notes: Levels change at the falling edge; supply rests low between frames
`timescale 1ns/1ns
module hps_programmer #(
    parameter int BIT_CYC = 8
) (
    input wire logic sys_clk,
    input wire logic out_pin,
    output logic supply_hi
);
    import hps_pkg::*;
    initial supply_hi = 1'b0;
    // One frame: start bit, op, address, data MSB first, then the reply window
    task automatic send(input hps_op_t op, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                        input int gap, output logic [DATA_W-1:0] rdata);
        logic [FRAME_BITS-1:0] frame;
        frame = {op, addr, data};
        rdata = '0;
        @(negedge sys_clk);
        supply_hi = 1'b1;
        repeat (BIT_CYC) @(negedge sys_clk);
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            supply_hi = frame[i];
            repeat (BIT_CYC) @(negedge sys_clk);
        end
        supply_hi = 1'b0;
        repeat (6) @(negedge sys_clk);
        for (int k = DATA_W - 1; k >= 0; k--) begin
            rdata[k] = out_pin;
            repeat (BIT_CYC) @(negedge sys_clk);
        end
        repeat (gap) @(negedge sys_clk);
    endtask : send
endmodule : hps_programmer

// ### sim/hps_param_regs_bench.sv
// Purpose: Self-checking bench of the hall switch parameter block
// Assumes: Programmer model sends frames; the lock cell is emulated here
// Notes: Bit time of 8 cycles keeps the run short
`timescale 1ns/1ns
module hps_param_regs_bench;
    import hps_pkg::*;
    localparam int BC = 8;
    logic sys_clk, rst_b, supply_hi, lock_cell, raw_valid, out_pin, lock_cell_set, nv_lock;
    logic [RAW_W-1:0] raw_sample;
    logic [FMT_W-1:0] output_format;
    logic [3:0] comp_range;
    logic [LIN_W-1:0] linear_temp_coeff;
    logic [QUAD_W-1:0] quadratic_temp_coeff;
    logic [DATA_W-1:0] rd, d;
    logic [TC_W-1:0] tc;
    logic [3:0] grp_hot;
    logic [DATA_W-1:0] msk [1:4] = '{14'h3fff, 14'h0fff, 14'h00ff, 14'h01ff};
    logic [DATA_W-1:0] cal_gain [0:3] = '{14'd950, 14'd614, 14'd657, 14'd1313};
    logic [DATA_W-1:0] ub [0:3];
    int n_errors, compares, seed;

    hps_param_regs #(.BIT_CYC(BC)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .supply_hi(supply_hi),
        .lock_cell(lock_cell), .raw_sample(raw_sample), .raw_valid(raw_valid), .output_format(output_format),
        .out_pin(out_pin), .lock_cell_set(lock_cell_set), .comp_range(comp_range),
        .linear_temp_coeff(linear_temp_coeff), .quadratic_temp_coeff(quadratic_temp_coeff));
    hps_programmer #(.BIT_CYC(BC)) prog (.sys_clk(sys_clk), .out_pin(out_pin), .supply_hi(supply_hi));

    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    function automatic logic [DATA_W-1:0] rev14(input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] r;
        for (int i = 0; i < DATA_W; i++) r[i] = v[DATA_W-1-i];
        return r;
    endfunction : rev14
    // Clamped processed signal; inputs chosen so the product divides exactly
    function automatic logic [DATA_W-1:0] exp_proc(input int g, input int r, input int off);
        int s, mx;
        s = (g * r) / 2048 + off - 2048;
        mx = (off < 2048) ? off - 2048 + 1023 : 1023;
        if (s > mx) s = mx;
        if (s < 0) s = 0;
        return s[DATA_W-1:0];
    endfunction : exp_proc

    task automatic complete_run;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
        compares++;
        if (got !== want) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : check
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] dummy;
        prog.send(OP_WRITE, a, v, 2 + ($random(seed) & 7), dummy);
    endtask : wr
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
        prog.send(OP_READ, a, 14'h0000, 2 + ($random(seed) & 7), rd);
        check(rd, want);
    endtask : rdc
    task automatic load(input logic [DATA_W-1:0] g, off, rel, opr);
        wr(A_GAIN, g);
        wr(A_OFF, off);
        wr(A_REL, rel);
        wr(A_OPR, opr);
    endtask : load
    task automatic set_raw(input logic [RAW_W-1:0] r);
        @(negedge sys_clk);
        raw_sample = r;
        raw_valid = 1'b1;
        @(negedge sys_clk);
        raw_valid = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : set_raw
    // Power cycle; the non-volatile cell keeps a lock request across it
    task automatic power_cycle;
        @(negedge sys_clk);
        nv_lock = nv_lock | lock_cell_set;
        rst_b = 1'b0;
        lock_cell = nv_lock;
        repeat (16) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (12) @(negedge sys_clk);
    endtask : power_cycle

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        complete_run();
    end

    initial begin
        seed = 32'h8777;
        n_errors = 0;
        compares = 0;
        nv_lock = 1'b0;
        rst_b = 1'b0;
        lock_cell = 1'b0;
        raw_sample = '0;
        raw_valid = 1'b0;
        output_format = FMT_DIGITAL;
        power_cycle();
        check({out_pin, lock_cell_set, comp_range, linear_temp_coeff, quadratic_temp_coeff}, 14'h2400);
        rdc(A_TC, 14'h0100);
        $display("test reset done");
        for (int g = 0; g < 4; g++) begin
            tc = {2'(g), 8'($random(seed))};
            grp_hot = (g == 0) ? 4'h1 : (g == 2) ? 4'h2 : (g == 1) ? 4'h4 : 4'h8;
            wr(A_TC, {4'h0, tc});
            check({10'h000, comp_range}, {10'h000, grp_hot});
            check({6'h00, linear_temp_coeff, quadratic_temp_coeff}, {6'h00, tc[7:0]});
            rdc(A_TC, {4'h0, tc});
        end
        $display("test temp groups done");
        for (int i = 1; i < 5; i++) begin
            d = 14'($random(seed));
            wr(4'(i), d);
            rdc(4'(i), d & msk[i]);
        end
        for (int i = 0; i < UIB_N; i++) begin
            ub[i] = 14'($random(seed));
            wr(A_UIB0 + 4'(i), ub[i]);
        end
        prog.send(OP_STORE, A_UIB0, 14'h0000, 4, rd);
        for (int i = 0; i < UIB_N; i++) begin
            rdc(A_UIB0 + 4'(i), ub[i] & 14'h1fff);
        end
        for (int a = 12; a < 16; a++) begin
            wr(4'(a), 14'h3fff);
            rdc(4'(a), 14'h0000);
        end
        $display("test registers done");
        load(14'h0800, 14'h0800, 14'd100, 14'd300);
        set_raw(14'd700);
        check({13'h0000, out_pin}, 14'h0000);
        set_raw(14'd400);
        check({13'h0000, out_pin}, 14'h0000);
        set_raw(14'd100);
        check({13'h0000, out_pin}, 14'h0001);
        set_raw(14'd400);
        check({13'h0000, out_pin}, 14'h0001);
        set_raw(14'h3fce);
        rdc(A_RAW, 14'h3fce);
        rdc(A_PROC, rev14(exp_proc(2048, -50, 2048)));
        set_raw(14'd2000);
        rdc(A_PROC, rev14(exp_proc(2048, 2000, 2048)));
        wr(A_OFF, 14'd1948);
        set_raw(14'd2000);
        rdc(A_PROC, rev14(exp_proc(2048, 2000, 1948)));
        @(negedge sys_clk);
        output_format = 3'h4;
        rdc(A_PROC, 14'h0000);
        @(negedge sys_clk);
        output_format = FMT_DIGITAL;
        for (int i = 0; i < 4; i++) begin
            load(cal_gain[i], 14'd2048, 14'd0, 14'd511);
            set_raw(14'h0800);
            rdc(A_PROC, rev14(exp_proc(int'(cal_gain[i]), 2048, 2048)));
        end
        $display("test signal path done");
        wr(A_GUARD, 14'h0001);
        check({13'h0000, lock_cell_set}, 14'h0001);
        wr(A_GUARD, 14'h0000);
        check({13'h0000, lock_cell_set}, 14'h0001);
        rdc(A_GUARD, 14'h0001);
        wr(A_TC, 14'h0300);
        check({10'h000, comp_range}, 14'h0008);
        power_cycle();
        wr(A_TC, 14'h0000);
        check({10'h000, comp_range}, 14'h0004);
        rdc(A_TC, 14'h3fff);
        $display("test lock done");
        complete_run();
    end
endmodule : hps_param_regs_bench
